// ---- shared/vic_pkg.sv ----
`default_nettype none
package vic_pkg;
   localparam int unsigned NUM_SRC                 = 12;
   localparam int unsigned NUM_LVL                 = 2;
   // Special function register addresses
   localparam logic [7:0]  ADDR_PRIMARY_IRQ_ENABLE   = 8'hA8;
   localparam logic [7:0]  ADDR_PRIMARY_IRQ_PRIORITY = 8'hB8;
   localparam logic [7:0]  ADDR_EXT_PIN_IRQ_CONFIG   = 8'hE4;
   localparam logic [7:0]  ADDR_EXTENDED_IRQ_ENABLE  = 8'hE6;
   localparam logic [7:0]  ADDR_EXTENDED_IRQ_PRIORITY = 8'hF6;
   // Field positions
   localparam int unsigned GLOBAL_IRQ_ENABLE_BIT   = 7;
   localparam int unsigned PRIMARY_SRC_COUNT       = 6;
   localparam logic [7:0]  SRC_FIELD_MASK          = 8'h3F;
   // Reset values; low priority is the default
   localparam logic [7:0]  RST_PRIMARY_IRQ_ENABLE  = 8'h00;
   localparam logic [7:0]  RST_PRIMARY_IRQ_PRIORITY = 8'h00;
   localparam logic [7:0]  RST_EXT_PIN_IRQ_CONFIG  = 8'h00;
   localparam logic [7:0]  RST_EXTENDED_IRQ_ENABLE = 8'h00;
   localparam logic [7:0]  RST_EXTENDED_IRQ_PRIORITY = 8'h00;
   localparam logic [11:0] RST_PENDING             = 12'h000;
   // Sources whose pending flag hardware clears on vectoring
   localparam logic [11:0] AUTO_CLEAR_MASK         = 12'h00F;
   // Vector layout: first vector plus fixed stride
   localparam logic [15:0] VECTOR_BASE             = 16'h0003;
   localparam int unsigned VECTOR_STRIDE_SHIFT     = 3;
   // Long call timing
   localparam int unsigned CLK_HZ                  = 20_000_000;
   localparam int unsigned LONG_CALL_TO_VECTOR_CYCLES            = 4;
   localparam logic [2:0]  LONG_CALL_TO_VECTOR_CNT_LOAD          = 3'(LONG_CALL_TO_VECTOR_CYCLES);
   localparam logic [2:0]  LONG_CALL_TO_VECTOR_CNT_IDLE          = 3'h0;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } vic_sfr_req_t;

   typedef struct packed {
      logic instr_done;
      logic return_from_interrupt_done;
   } vic_cpu_status_t;

   typedef struct packed {
      logic        take;
      logic        long_call_to_vector_busy;
      logic [15:0] vector;
      logic        high_level;
   } vic_vector_req_t;
endpackage : vic_pkg
`default_nettype wire

// ---- hdl/vic_controller.sv ----
`default_nettype none
module vic_controller (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     sys_rst,
   // Special function register access
   input  wire vic_pkg::vic_sfr_req_t    sfr_req,
   output logic [7:0]                    sfr_rdata,
   // Pending flag sources
   input  wire logic [11:0]              src_event,
   input  wire logic [11:0]              flag_wr,
   input  wire logic [11:0]              flag_wdata,
   output logic [11:0]                   pending,
   // Instruction sequencer
   input  wire vic_pkg::vic_cpu_status_t cpu_status,
   output vic_pkg::vic_vector_req_t      vector_req,
   output logic [1:0]                    in_service,
   output logic [7:0]                    ext_pin_irq_config
);

   logic [7:0]  primary_irq_enable_reg;
   logic [7:0]  primary_irq_priority_reg;
   logic [7:0]  ext_pin_irq_config_reg;
   logic [7:0]  extended_irq_enable_reg;
   logic [7:0]  extended_irq_priority_reg;
   logic [7:0]  sfr_rdata_reg;
   logic [11:0] pending_reg;
   logic [11:0] pending_next;
   logic [1:0]  in_service_reg;
   logic        cand_valid_reg;
   logic [3:0]  cand_idx_reg;
   logic        cand_high_reg;
   logic        take_reg;
   logic        take_high_reg;
   logic [15:0] vector_reg;
   logic [2:0]  long_call_to_vector_cnt_reg;
   logic        long_call_to_vector_busy_reg;

   logic        global_irq_enable;
   logic [11:0] src_enable;
   logic [11:0] src_high;
   logic [11:0] active;
   logic [11:0] elig_high;
   logic [11:0] elig_low;
   logic        win_valid;
   logic [3:0]  win_idx;
   logic        win_high;
   logic        take_now;
   logic [11:0] auto_clear;
   logic [7:0]  primary_enable_mask;
   logic [7:0]  rd_value;
   logic        wr_primary_enable;
   logic        wr_primary_priority;
   logic        wr_ext_pin_config;
   logic        wr_extended_enable;
   logic        wr_extended_priority;

   // Enable and priority bit maps; sources past the primary register
   // continue in the extended pair from bit zero
   assign global_irq_enable = primary_irq_enable_reg[vic_pkg::GLOBAL_IRQ_ENABLE_BIT];
   generate
      for (genvar s = 0; s < vic_pkg::NUM_SRC; s++) begin : g_map
         if (s < vic_pkg::PRIMARY_SRC_COUNT) begin : g_primary
            assign src_enable[s] = primary_irq_enable_reg[s];
            assign src_high[s]   = primary_irq_priority_reg[s];
         end else begin : g_extended
            assign src_enable[s] = extended_irq_enable_reg[s - vic_pkg::PRIMARY_SRC_COUNT];
            assign src_high[s]   = extended_irq_priority_reg[s - vic_pkg::PRIMARY_SRC_COUNT];
         end
      end
   endgenerate
   // Disabled sources and a cleared global bit mask the flag out
   assign active = global_irq_enable ? (pending_reg & src_enable) : 12'h000;

   // High routine is never preempted; low yields only to high
   assign elig_high = in_service_reg[1] ? 12'h000 : (active & src_high);
   assign elig_low  = (in_service_reg[1] | in_service_reg[0]) ? 12'h000
                                                             : (active & ~src_high);

   // Priority decode: level first, then lowest source number
   always_comb begin
      win_valid = 1'b0;
      win_idx   = 4'h0;
      win_high  = 1'b0;
      for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (elig_low[i]) begin
            win_valid = 1'b1;
            win_idx   = 4'(i);
            win_high  = 1'b0;
         end
      end
      for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (elig_high[i]) begin
            win_valid = 1'b1;
            win_idx   = 4'(i);
            win_high  = 1'b1;
         end
      end
   end

   // Detect stage, sampled every cycle
   // A take drops the candidate so one boundary never takes twice
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cand_valid_reg <= 1'b0;
         cand_idx_reg   <= 4'h0;
         cand_high_reg  <= 1'b0;
      end else begin
         cand_valid_reg <= win_valid & ~take_now;
         cand_idx_reg   <= win_idx;
         cand_high_reg  <= win_high;
      end
   end

   // Candidate reflects last cycle's enables, so a clear racing a
   // one-cycle successor can still be taken; longer ones re-sample
   // Boundary of the return itself never vectors: one more
   // instruction runs first
   assign take_now = cand_valid_reg & cpu_status.instr_done
                     & ~cpu_status.return_from_interrupt_done & ~long_call_to_vector_busy_reg;

   // Long call request and its four-cycle window
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         take_reg      <= 1'b0;
         take_high_reg <= 1'b0;
         vector_reg    <= vic_pkg::VECTOR_BASE;
      end else begin
         take_reg <= take_now;
         if (take_now) begin
            take_high_reg <= cand_high_reg;
            vector_reg    <= vic_pkg::VECTOR_BASE
                             + (16'(cand_idx_reg) << vic_pkg::VECTOR_STRIDE_SHIFT);
         end
      end
   end

   // Busy drops with the last count, so the next boundary may take
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         long_call_to_vector_cnt_reg  <= vic_pkg::LONG_CALL_TO_VECTOR_CNT_IDLE;
         long_call_to_vector_busy_reg <= 1'b0;
      end else if (take_now) begin
         long_call_to_vector_cnt_reg  <= vic_pkg::LONG_CALL_TO_VECTOR_CNT_LOAD;
         long_call_to_vector_busy_reg <= 1'b1;
      end else if (long_call_to_vector_cnt_reg != vic_pkg::LONG_CALL_TO_VECTOR_CNT_IDLE) begin
         long_call_to_vector_cnt_reg  <= long_call_to_vector_cnt_reg - 3'h1;
         long_call_to_vector_busy_reg <= (long_call_to_vector_cnt_reg != 3'h1);
      end
   end

   // In-service levels; the sequencer returns to the saved address,
   // so only the level state is unwound here
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         in_service_reg <= 2'b00;
      end else if (take_now) begin
         in_service_reg[cand_high_reg ? 1 : 0] <= 1'b1;
      end else if (cpu_status.instr_done && cpu_status.return_from_interrupt_done) begin
         if (in_service_reg[1]) begin
            in_service_reg[1] <= 1'b0;
         end else begin
            in_service_reg[0] <= 1'b0;
         end
      end
   end

   // Pending flags: events and software writes of one set alike,
   // an event in the clearing cycle wins
   assign auto_clear = take_now ? (vic_pkg::AUTO_CLEAR_MASK
                                   & (12'h001 << cand_idx_reg)) : 12'h000;

   generate
      for (genvar g = 0; g < vic_pkg::NUM_SRC; g++) begin : g_pend
         always_comb begin
            pending_next[g] = pending_reg[g];
            if (flag_wr[g]) begin
               pending_next[g] = flag_wdata[g];
            end else if (auto_clear[g]) begin
               pending_next[g] = 1'b0;
            end
            if (src_event[g]) begin
               pending_next[g] = 1'b1;
            end
         end
      end
   endgenerate

   // Flags hold through the long call; only a vectored source among 0 to 3 clears
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pending_reg <= vic_pkg::RST_PENDING;
      end else begin
         pending_reg <= pending_next;
      end
   end

   // Write strobes; an unmapped address matches none and is dropped
   assign wr_primary_enable    = sfr_req.wr
                                 & (sfr_req.addr == vic_pkg::ADDR_PRIMARY_IRQ_ENABLE);
   assign wr_primary_priority  = sfr_req.wr
                                 & (sfr_req.addr == vic_pkg::ADDR_PRIMARY_IRQ_PRIORITY);
   assign wr_ext_pin_config    = sfr_req.wr
                                 & (sfr_req.addr == vic_pkg::ADDR_EXT_PIN_IRQ_CONFIG);
   assign wr_extended_enable   = sfr_req.wr
                                 & (sfr_req.addr == vic_pkg::ADDR_EXTENDED_IRQ_ENABLE);
   assign wr_extended_priority = sfr_req.wr
                                 & (sfr_req.addr == vic_pkg::ADDR_EXTENDED_IRQ_PRIORITY);
   // Reserved bits are never stored, so they read back as zero
   assign primary_enable_mask  = vic_pkg::SRC_FIELD_MASK
                                 | 8'(1 << vic_pkg::GLOBAL_IRQ_ENABLE_BIT);

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         primary_irq_enable_reg <= vic_pkg::RST_PRIMARY_IRQ_ENABLE;
      end else if (wr_primary_enable) begin
         primary_irq_enable_reg <= sfr_req.wdata & primary_enable_mask;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         primary_irq_priority_reg <= vic_pkg::RST_PRIMARY_IRQ_PRIORITY;
      end else if (wr_primary_priority) begin
         primary_irq_priority_reg <= sfr_req.wdata & vic_pkg::SRC_FIELD_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ext_pin_irq_config_reg <= vic_pkg::RST_EXT_PIN_IRQ_CONFIG;
      end else if (wr_ext_pin_config) begin
         ext_pin_irq_config_reg <= sfr_req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         extended_irq_enable_reg <= vic_pkg::RST_EXTENDED_IRQ_ENABLE;
      end else if (wr_extended_enable) begin
         extended_irq_enable_reg <= sfr_req.wdata & vic_pkg::SRC_FIELD_MASK;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         extended_irq_priority_reg <= vic_pkg::RST_EXTENDED_IRQ_PRIORITY;
      end else if (wr_extended_priority) begin
         extended_irq_priority_reg <= sfr_req.wdata & vic_pkg::SRC_FIELD_MASK;
      end
   end

   // Register reads, one cycle later; other addresses read zero
   always_comb begin
      rd_value = 8'h00;
      unique case (sfr_req.addr)
         vic_pkg::ADDR_PRIMARY_IRQ_ENABLE:    rd_value = primary_irq_enable_reg;
         vic_pkg::ADDR_PRIMARY_IRQ_PRIORITY:  rd_value = primary_irq_priority_reg;
         vic_pkg::ADDR_EXT_PIN_IRQ_CONFIG:    rd_value = ext_pin_irq_config_reg;
         vic_pkg::ADDR_EXTENDED_IRQ_ENABLE:   rd_value = extended_irq_enable_reg;
         vic_pkg::ADDR_EXTENDED_IRQ_PRIORITY: rd_value = extended_irq_priority_reg;
         default:                             rd_value = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         sfr_rdata_reg <= 8'h00;
      end else if (sfr_req.rd) begin
         sfr_rdata_reg <= rd_value;
      end
   end

   assign sfr_rdata              = sfr_rdata_reg;
   assign pending                = pending_reg;
   assign in_service             = in_service_reg;
   assign ext_pin_irq_config     = ext_pin_irq_config_reg;
   assign vector_req.take        = take_reg;
   assign vector_req.long_call_to_vector_busy  = long_call_to_vector_busy_reg;
   assign vector_req.vector      = vector_reg;
   assign vector_req.high_level  = take_high_reg;

endmodule : vic_controller
`default_nettype wire

// ---- verification/vic_checker.sv ----
`default_nettype none
module vic_checker (
   // Clock and reset
   input wire logic                     sys_clk,
   input wire logic                     sys_rst,
   // Flags
   input wire logic [11:0]              src_event,
   input wire logic [11:0]              pending,
   // Sequencer side
   input wire vic_pkg::vic_cpu_status_t cpu_status,
   input wire vic_pkg::vic_vector_req_t vector_req,
   input wire logic [1:0]               in_service
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_call;
      vector_req.long_call_to_vector_busy [*4] ##1 !vector_req.long_call_to_vector_busy;
   endsequence
   sequence s_return;
      cpu_status.instr_done && cpu_status.return_from_interrupt_done;
   endsequence
   a_call_four_cycles: assert property (vector_req.take |-> s_call)
      else $error("long call length wrong");
   a_take_at_boundary: assert property (
      vector_req.take |-> $past(cpu_status.instr_done && !cpu_status.return_from_interrupt_done
                                && !vector_req.long_call_to_vector_busy))
      else $error("take without plain boundary");
   a_return_no_take: assert property (s_return |=> !vector_req.take)
      else $error("take on return boundary");
   a_take_needs_flag: assert property (
      vector_req.take |-> $past(pending, 2) != 12'h000)
      else $error("take without pending flag");
   a_vector_slot: assert property (
      vector_req.take |-> vector_req.vector[2:0] == 3'h3 && vector_req.vector <= 16'h005B)
      else $error("vector outside table");
   a_service_marked: assert property (vector_req.take |-> in_service[vector_req.high_level])
      else $error("in service not set");
   a_high_not_preempted: assert property (vector_req.take |-> !$past(in_service[1]))
      else $error("high routine preempted");
   a_low_needs_high: assert property (
      vector_req.take && $past(in_service[0]) |-> vector_req.high_level)
      else $error("low routine preempted by low");
   a_return_clears: assert property (
      s_return |=> in_service == ($past(in_service[1]) ? {1'h0, $past(in_service[0])} : 2'h0))
      else $error("return did not clear in service");
   a_event_sets_flag: assert property (
      |src_event |=> (pending & $past(src_event)) == $past(src_event))
      else $error("event did not set flag");
endmodule : vic_checker
bind vic_controller vic_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .src_event(src_event), .pending(pending), .cpu_status(cpu_status),
   .vector_req(vector_req), .in_service(in_service));
`default_nettype wire

// ---- verification/vic_cpu_model.sv ----
`default_nettype none
module vic_cpu_model #(
   parameter int unsigned GAP = 2
) (
   // Clock and reset
   input wire logic                     sys_clk,
   input wire logic                     sys_rst,
   // Bench controls
   input wire logic                     run,
   input wire logic                     return_from_interrupt_req,
   // Controller side
   input wire vic_pkg::vic_vector_req_t vector_req,
   output vic_pkg::vic_cpu_status_t     cpu_status
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] gap_reg;
   logic       return_from_interrupt_pend_reg;
   always_ff @(posedge sys_clk) begin
      if (sys_rst || cpu_status.return_from_interrupt_done) begin
         return_from_interrupt_pend_reg <= 1'h0;
      end else if (return_from_interrupt_req) begin
         return_from_interrupt_pend_reg <= 1'h1;
      end
   end
   // No boundary during the long call, as a real sequencer is busy then
   always_ff @(posedge sys_clk) begin
      if (sys_rst || !run || vector_req.long_call_to_vector_busy) begin
         gap_reg <= 4'(GAP);
         cpu_status <= '0;
      end else begin
         cpu_status.instr_done <= (gap_reg == 4'h0);
         cpu_status.return_from_interrupt_done <= (gap_reg == 4'h0) && return_from_interrupt_pend_reg;
         gap_reg <= (gap_reg == 4'h0) ? 4'(GAP) : gap_reg - 4'h1;
      end
   end
endmodule : vic_cpu_model
`default_nettype wire

// ---- verification/vectored_interrupt_controller_tb.sv ----
`default_nettype none
module vectored_interrupt_controller_tb;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [7:0] rexp;
   } vic_row_t;
   localparam vic_row_t ROWS [6] = '{'{8'hA8, 8'hFF, 8'hBF}, '{8'hB8, 8'hFF, 8'h3F},
      '{8'hE4, 8'hA5, 8'hA5}, '{8'hE6, 8'hFF, 8'h3F}, '{8'hF6, 8'hFF, 8'h3F},
      '{8'h90, 8'hFF, 8'h00}};
   logic                      sys_clk = 1'h0;
   logic                      sys_rst = 1'h1;
   logic                      run = 1'h0;
   logic                      return_from_interrupt_req = 1'h0;
   logic [11:0]               src_event = '0;
   logic [11:0]               flag_wr = '0;
   logic [11:0]               flag_wdata = '0;
   vic_pkg::vic_sfr_req_t     sfr_req = '0;
   logic [7:0]                sfr_rdata;
   logic [11:0]               pending;
   vic_pkg::vic_cpu_status_t  cpu_status;
   vic_pkg::vic_vector_req_t  vector_req;
   logic [1:0]                in_service;
   logic [7:0]                ext_cfg;
   int                        fail_count = 0;
   int                        total_checks = 0;
   always #25 sys_clk = ~sys_clk;
   vic_controller DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .src_event(src_event), .flag_wr(flag_wr),
      .flag_wdata(flag_wdata), .pending(pending), .cpu_status(cpu_status),
      .vector_req(vector_req), .in_service(in_service), .ext_pin_irq_config(ext_cfg));
   vic_cpu_model u_cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .run(run),
      .return_from_interrupt_req(return_from_interrupt_req), .vector_req(vector_req), .cpu_status(cpu_status));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic special_function_register(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge sys_clk);
      sfr_req <= '{rd: !wr, wr: wr, addr: addr, wdata: data};
      @(posedge sys_clk);
      sfr_req <= '0;
      #1;
   endtask : special_function_register
   task automatic ev(input logic [11:0] set, input logic [11:0] wr, input logic [11:0] data);
      @(posedge sys_clk);
      src_event <= set;
      flag_wr <= wr;
      flag_wdata <= data;
      @(posedge sys_clk);
      src_event <= '0;
      flag_wr <= '0;
   endtask : ev
   task automatic quiet;
      repeat (20) begin
         @(posedge sys_clk);
         #1;
         chk(vector_req.take, 1'h0);
      end
   endtask : quiet
   // Bounded waits: a hung controller ends the run with a mismatch
   task automatic take_vec(input logic [15:0] vec);
      int i;
      for (i = 0; i < 60 && vector_req.take !== 1'h1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      if (vector_req.take !== 1'h1) begin
         fail_count++;
         tally_and_finish();
      end
      chk(vector_req.vector, vec);
   endtask : take_vec
   task automatic return_from_interrupt;
      int i;
      @(posedge sys_clk);
      return_from_interrupt_req <= 1'h1;
      @(posedge sys_clk);
      return_from_interrupt_req <= 1'h0;
      for (i = 0; i < 60 && cpu_status.return_from_interrupt_done !== 1'h1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      if (cpu_status.return_from_interrupt_done !== 1'h1) begin
         fail_count++;
         tally_and_finish();
      end
      @(posedge sys_clk);
      #1;
   endtask : return_from_interrupt
   initial begin
      repeat (16) @(posedge sys_clk);
      sys_rst <= 1'h0;
      foreach (ROWS[i]) begin
         special_function_register(1'h1, ROWS[i].addr, ROWS[i].wdata);
         special_function_register(1'h0, ROWS[i].addr, 8'h00);
         chk(sfr_rdata, ROWS[i].rexp);
      end
      chk(ext_cfg, 8'hA5);
      // Mid-run reset must bring every register back to zero
      @(posedge sys_clk);
      sys_rst <= 1'h1;
      @(posedge sys_clk);
      sys_rst <= 1'h0;
      for (int i = 0; i < 5; i++) begin
         special_function_register(1'h0, ROWS[i].addr, 8'h00);
         chk(sfr_rdata, 8'h00);
      end
      run <= 1'h1;
      ev(12'h000, 12'h002, 12'h002);
      special_function_register(1'h1, 8'hA8, 8'h02);
      quiet();
      chk(pending, 12'h002);
      special_function_register(1'h1, 8'hA8, 8'h82);
      take_vec(16'h000B);
      chk({in_service, pending}, 14'h1000);
      special_function_register(1'h1, 8'hB8, 8'h20);
      special_function_register(1'h1, 8'hA8, 8'hB2);
      ev(12'h020, 12'h000, 12'h000);
      take_vec(16'h002B);
      chk({vector_req.high_level, in_service}, 3'h7);
      ev(12'h010, 12'h000, 12'h000);
      quiet();
      chk(pending, 12'h030);
      return_from_interrupt();
      chk(in_service, 2'h1);
      take_vec(16'h002B);
      ev(12'h000, 12'h020, 12'h000);
      return_from_interrupt();
      quiet();
      return_from_interrupt();
      take_vec(16'h0023);
      ev(12'h000, 12'h010, 12'h000);
      return_from_interrupt();
      chk(in_service, 2'h0);
      special_function_register(1'h1, 8'hB8, 8'h08);
      special_function_register(1'h1, 8'hA8, 8'h8E);
      ev(12'h00E, 12'h000, 12'h000);
      take_vec(16'h001B);
      return_from_interrupt();
      take_vec(16'h000B);
      // Global clear padded by a second clear, then read inside the routine
      special_function_register(1'h1, 8'hA8, 8'h0E);
      special_function_register(1'h1, 8'hA8, 8'h0E);
      special_function_register(1'h0, 8'hA8, 8'h00);
      chk(sfr_rdata, 8'h0E);
      return_from_interrupt();
      quiet();
      chk(pending, 12'h004);
      special_function_register(1'h1, 8'hA8, 8'h8E);
      take_vec(16'h0013);
      chk(in_service, 2'h1);
      tally_and_finish();
   end
endmodule : vectored_interrupt_controller_tb
`default_nettype wire
